// [hdl/debug_uart_pkg.sv]
// constants of the debug serial unit: register map, field layout, timing
// assumes a 100 MHz system clock and byte addressing on the register bus
package debug_uart_pkg;

   // ************************************************************
   // register offsets, byte addresses
   // ************************************************************
   localparam logic [7:0]  OFS_CTRL       = 8'h00;
   localparam logic [7:0]  OFS_MODE       = 8'h04;
   localparam logic [7:0]  OFS_IEN_SET    = 8'h08;
   localparam logic [7:0]  OFS_IEN_CLR    = 8'h0c;
   localparam logic [7:0]  OFS_IEN_VIEW   = 8'h10;
   localparam logic [7:0]  OFS_STATUS     = 8'h14;
   localparam logic [7:0]  OFS_RX_HOLD    = 8'h18;
   localparam logic [7:0]  OFS_TX_HOLD    = 8'h1c;

   // ************************************************************
   // control command bits
   // ************************************************************
   localparam int          CTRL_RX_RESET  = 2;
   localparam int          CTRL_TX_RESET  = 3;
   localparam int          CTRL_RX_ON     = 4;
   localparam int          CTRL_RX_OFF    = 5;
   localparam int          CTRL_TX_ON     = 6;
   localparam int          CTRL_TX_OFF    = 7;
   localparam int          CTRL_CLR_ERR   = 8;

   // ************************************************************
   // mode fields
   // ************************************************************
   localparam int          MODE_PAR_LSB   = 9;
   localparam int          MODE_CHM_LSB   = 14;
   localparam logic [31:0] MODE_MASK      = 32'h0000ce00;
   localparam logic [31:0] MODE_RESET     = 32'h00000000;
   localparam logic [2:0]  PAR_EVEN       = 3'h0;
   localparam logic [2:0]  PAR_ODD        = 3'h1;
   localparam logic [2:0]  PAR_SPACE      = 3'h2;
   localparam logic [2:0]  PAR_MARK       = 3'h3;
   localparam logic [1:0]  CH_NORMAL      = 2'h0;
   localparam logic [1:0]  CH_ECHO        = 2'h1;
   localparam logic [1:0]  CH_LOCAL_LOOP  = 2'h2;
   localparam logic [1:0]  CH_REMOTE_LOOP = 2'h3;

   // ************************************************************
   // status, enable and mask bit layout
   // ************************************************************
   localparam int          ST_DCC_RD      = 31;
   localparam int          ST_DCC_WR      = 30;
   localparam int          ST_RXBUF_FULL  = 12;
   localparam int          ST_TXBUF_EMPTY = 11;
   localparam int          ST_TX_IDLE     = 9;
   localparam int          ST_PAR_ERR     = 7;
   localparam int          ST_FRAME_ERR   = 6;
   localparam int          ST_OVR_ERR     = 5;
   localparam int          ST_TXDMA_DONE  = 4;
   localparam int          ST_RXDMA_DONE  = 3;
   localparam int          ST_TX_FREE     = 1;
   localparam int          ST_RX_AVAIL    = 0;
   localparam logic [31:0] IRQ_BITS       = 32'hc0001afb;
   localparam logic [31:0] MASK_RESET     = 32'h00000000;

   // ************************************************************
   // serial timing
   // ************************************************************
   localparam int          CLK_PERIOD_NS  = 10;
   localparam int          BIT_TIME_NS    = 160;
   localparam logic [7:0]  BIT_CYCLES     = 8'(BIT_TIME_NS / CLK_PERIOD_NS);
   localparam logic [7:0]  HALF_CYCLES    = 8'(BIT_TIME_NS / CLK_PERIOD_NS / 2);
   localparam logic [3:0]  TX_BITS_PAR    = 4'hb;
   localparam logic [3:0]  TX_BITS_NOPAR  = 4'ha;

   typedef enum logic [0:0] {RX_IDLE, RX_BUSY} rx_state_e;

endpackage

// [hdl/debug_uart_regs.sv]
// debug serial unit: register file, transmitter, receiver, test modes
// assumes an Avalon-MM master on clk and same-clock dma and debug signals
//
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
module debug_uart_regs (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        ce,
   input  wire logic [7:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   input  wire logic        rxd,
   output logic             txd,
   input  wire logic        rxDmaEnd,
   input  wire logic        txDmaEnd,
   input  wire logic        rxDmaBufFull,
   input  wire logic        txDmaBufEmpty,
   input  wire logic        dccReadPending,
   input  wire logic        dccWritePending,
   output logic             irq
);

   // ************************************************************
   // declarations
   // ************************************************************
   logic                      ack;
   logic [31:0]               modeReg;
   logic [31:0]               maskReg;
   logic                      rxEn;
   logic                      txEn;
   logic                      rxMeta;
   logic                      rxSync2;
   logic                      rxSync3;
   logic                      rxLevel;
   logic                      rxAvail;
   logic [7:0]                rxHold;
   logic                      ovrErr;
   logic                      frameErr;
   logic                      parErr;
   logic                      holdFull;
   logic [7:0]                holdData;
   logic                      shiftBusy;
   logic [9:0]                txShift;
   logic [3:0]                txLeft;
   logic [7:0]                txTimer;
   logic                      txLine;
   debug_uart_pkg::rx_state_e rxState;
   logic [7:0]                rxTimer;
   logic [3:0]                rxIdx;
   logic [7:0]                rxData;
   logic                      rxParBit;

   // ************************************************************
   // bus decode
   // ************************************************************
   wire        busReq    = read | write;
   wire        wrDone    = write & ack;
   wire        rdDone    = read & ack;
   wire        wrCtrl    = wrDone & (address == debug_uart_pkg::OFS_CTRL);
   wire        wrMode    = wrDone & (address == debug_uart_pkg::OFS_MODE);
   wire        wrIenSet  = wrDone & (address == debug_uart_pkg::OFS_IEN_SET);
   wire        wrIenClr  = wrDone & (address == debug_uart_pkg::OFS_IEN_CLR);
   wire        wrTxHold  = wrDone & (address == debug_uart_pkg::OFS_TX_HOLD);
   wire        rdRxHold  = rdDone & (address == debug_uart_pkg::OFS_RX_HOLD);
   wire        cmdRxRst  = wrCtrl & writedata[debug_uart_pkg::CTRL_RX_RESET];
   wire        cmdTxRst  = wrCtrl & writedata[debug_uart_pkg::CTRL_TX_RESET];
   wire        cmdRxOn   = wrCtrl & writedata[debug_uart_pkg::CTRL_RX_ON];
   wire        cmdRxOff  = wrCtrl & writedata[debug_uart_pkg::CTRL_RX_OFF];
   wire        cmdTxOn   = wrCtrl & writedata[debug_uart_pkg::CTRL_TX_ON];
   wire        cmdTxOff  = wrCtrl & writedata[debug_uart_pkg::CTRL_TX_OFF];
   wire        cmdClrErr = wrCtrl & writedata[debug_uart_pkg::CTRL_CLR_ERR];
   wire [2:0]  parType  = modeReg[debug_uart_pkg::MODE_PAR_LSB +: 3];
   wire [1:0]  channel_mode_sel   = modeReg[debug_uart_pkg::MODE_CHM_LSB +: 2];
   wire        parOn    = ~parType[2];
   wire        modeLoc  = channel_mode_sel == debug_uart_pkg::CH_LOCAL_LOOP;
   wire        modeRem  = channel_mode_sel == debug_uart_pkg::CH_REMOTE_LOOP;
   wire        rxIn     = modeLoc ? txLine : rxLevel;
   wire        rxActive = rxEn & ~modeRem;
   wire        txActive = txEn & ~modeRem;

   // ************************************************************
   // status word
   // ************************************************************
   wire        txFree   = txEn & ~holdFull;
   wire        txIdle   = txEn & ~holdFull & ~shiftBusy;
   logic [31:0] statusWord;
   always_comb begin
      statusWord = 32'h00000000;
      statusWord[debug_uart_pkg::ST_DCC_RD]      = dccReadPending;
      statusWord[debug_uart_pkg::ST_DCC_WR]      = dccWritePending;
      statusWord[debug_uart_pkg::ST_RXBUF_FULL]  = rxDmaBufFull;
      statusWord[debug_uart_pkg::ST_TXBUF_EMPTY] = txDmaBufEmpty;
      statusWord[debug_uart_pkg::ST_TX_IDLE]     = txIdle;
      statusWord[debug_uart_pkg::ST_PAR_ERR]     = parErr;
      statusWord[debug_uart_pkg::ST_FRAME_ERR]   = frameErr;
      statusWord[debug_uart_pkg::ST_OVR_ERR]     = ovrErr;
      statusWord[debug_uart_pkg::ST_TXDMA_DONE]  = txDmaEnd;
      statusWord[debug_uart_pkg::ST_RXDMA_DONE]  = rxDmaEnd;
      statusWord[debug_uart_pkg::ST_TX_FREE]     = txFree;
      statusWord[debug_uart_pkg::ST_RX_AVAIL]    = rxAvail;
   end
   assign irq = |(statusWord & maskReg);

   // ************************************************************
   // read mux
   // ************************************************************
   logic [31:0] rdMux;
   always_comb begin
      unique case (address)
         debug_uart_pkg::OFS_MODE:     rdMux = modeReg;
         debug_uart_pkg::OFS_IEN_VIEW: rdMux = maskReg;
         debug_uart_pkg::OFS_STATUS:   rdMux = statusWord;
         debug_uart_pkg::OFS_RX_HOLD:  rdMux = {24'h000000, rxHold};
         default:                      rdMux = 32'h00000000;
      endcase
   end

   // ************************************************************
   // avalon slave: one wait cycle per access
   // ************************************************************
   assign waitrequest = busReq & ~ack;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ack      <= 1'b0;
         readdata <= 32'h00000000;
      end else if (ce) begin
         ack <= busReq & ~ack;
         if (read & ~ack) begin
            readdata <= rdMux;
         end
      end
   end

   // ************************************************************
   // mode, mask, enables
   // ************************************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         modeReg <= debug_uart_pkg::MODE_RESET;
         maskReg <= debug_uart_pkg::MASK_RESET;
         rxEn    <= 1'b0;
         txEn    <= 1'b0;
      end else if (ce) begin
         if (wrMode) begin
            modeReg <= writedata & debug_uart_pkg::MODE_MASK;
         end
         if (wrIenSet) begin
            maskReg <= maskReg | (writedata & debug_uart_pkg::IRQ_BITS);
         end else if (wrIenClr) begin
            maskReg <= maskReg & ~(writedata & debug_uart_pkg::IRQ_BITS);
         end
         if (cmdRxRst | cmdRxOff) begin
            rxEn <= 1'b0;
         end else if (cmdRxOn) begin
            rxEn <= 1'b1;
         end
         if (cmdTxRst | cmdTxOff) begin
            txEn <= 1'b0;
         end else if (cmdTxOn) begin
            txEn <= 1'b1;
         end
      end
   end

   // ************************************************************
   // receive pin synchroniser and filter
   // ************************************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rxMeta  <= 1'b1;
         rxSync2 <= 1'b1;
         rxSync3 <= 1'b1;
         rxLevel <= 1'b1;
      end else if (ce) begin
         rxMeta  <= rxd;
         rxSync2 <= rxMeta;
         rxSync3 <= rxSync2;
         if (rxSync2 == rxSync3) begin
            rxLevel <= rxSync3;
         end
      end
   end

   // ************************************************************
   // pin multiplexing per channel mode
   // ************************************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         txd <= 1'b1;
      end else if (ce) begin
         unique case (channel_mode_sel)
            debug_uart_pkg::CH_NORMAL:      txd <= txLine;
            debug_uart_pkg::CH_ECHO:        txd <= rxLevel;
            debug_uart_pkg::CH_LOCAL_LOOP:  txd <= 1'b1;
            debug_uart_pkg::CH_REMOTE_LOOP: txd <= rxLevel;
         endcase
      end
   end

   // ************************************************************
   // transmitter
   // ************************************************************
   wire        txBitEnd = shiftBusy &
                          (txTimer == debug_uart_pkg::BIT_CYCLES - 8'h01);
   wire        txLast   = txBitEnd & (txLeft == 4'h1);
   wire        txLoad   = txActive & holdFull & (~shiftBusy | txLast);
   wire        txPar    = ~parOn | (parType[1] ? parType[0]
                                               : ^holdData ^ parType[0]);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         holdFull  <= 1'b0;
         holdData  <= 8'h00;
         shiftBusy <= 1'b0;
         txShift   <= 10'h3ff;
         txLeft    <= 4'h0;
         txTimer   <= 8'h00;
         txLine    <= 1'b1;
      end else if (ce) begin
         if (cmdTxRst) begin
            holdFull  <= 1'b0;
            shiftBusy <= 1'b0;
            txLine    <= 1'b1;
         end else begin
            if (wrTxHold) begin
               holdFull <= 1'b1;
               holdData <= writedata[7:0];
            end else if (txLoad) begin
               holdFull <= 1'b0;
            end
            if (txLoad) begin
               shiftBusy <= 1'b1;
               txLine    <= 1'b0;
               txTimer   <= 8'h00;
               txShift   <= {1'b1, txPar, holdData};
               txLeft    <= parOn ? debug_uart_pkg::TX_BITS_PAR
                                  : debug_uart_pkg::TX_BITS_NOPAR;
            end else if (txLast) begin
               shiftBusy <= 1'b0;
               txLine    <= 1'b1;
            end else if (txBitEnd) begin
               txTimer <= 8'h00;
               txLine  <= txShift[0];
               txShift <= {1'b1, txShift[9:1]};
               txLeft  <= txLeft - 4'h1;
            end else if (shiftBusy) begin
               txTimer <= txTimer + 8'h01;
            end
         end
      end
   end
   // ************************************************************
   // receiver
   // ************************************************************
   wire [7:0]  rxTarget = (rxIdx == 4'h0) ? debug_uart_pkg::HALF_CYCLES - 8'h01
                                          : debug_uart_pkg::BIT_CYCLES - 8'h01;
   wire        rxHit    = (rxState == debug_uart_pkg::RX_BUSY) &
                          (rxTimer == rxTarget);
   wire [3:0]  rxStopAt = parOn ? 4'ha : 4'h9;
   wire        rxFinish = rxActive & rxHit & (rxIdx == rxStopAt);
   wire        rxExpPar = parType[1] ? parType[0] : ^rxData ^ parType[0];
   wire        rxBadPar = parOn & (rxParBit != rxExpPar);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rxState  <= debug_uart_pkg::RX_IDLE;
         rxTimer  <= 8'h00;
         rxIdx    <= 4'h0;
         rxData   <= 8'h00;
         rxParBit <= 1'b0;
      end else if (ce) begin
         if (!rxActive) begin
            rxState <= debug_uart_pkg::RX_IDLE;
         end else begin
            unique case (rxState)
               debug_uart_pkg::RX_IDLE: begin
                  rxTimer <= 8'h00;
                  rxIdx   <= 4'h0;
                  if (!rxIn) begin
                     rxState <= debug_uart_pkg::RX_BUSY;
                  end
               end
               debug_uart_pkg::RX_BUSY: begin
                  if (!rxHit) begin
                     rxTimer <= rxTimer + 8'h01;
                  end else begin
                     rxTimer <= 8'h00;
                     rxIdx   <= rxIdx + 4'h1;
                     if (rxIdx == 4'h0 && rxIn) begin
                        rxState <= debug_uart_pkg::RX_IDLE;
                     end else if (rxIdx == rxStopAt) begin
                        rxState <= debug_uart_pkg::RX_IDLE;
                     end else if (rxIdx == 4'h9) begin
                        rxParBit <= rxIn;
                     end else if (rxIdx != 4'h0) begin
                        rxData <= {rxIn, rxData[7:1]};
                     end
                  end
               end
            endcase
         end
      end
   end

   // ************************************************************
   // receive flags and holding register
   // ************************************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rxAvail  <= 1'b0;
         rxHold   <= 8'h00;
         ovrErr   <= 1'b0;
         frameErr <= 1'b0;
         parErr   <= 1'b0;
      end else if (ce) begin
         if (rxFinish) begin
            rxAvail <= 1'b1;
            rxHold  <= rxData;
         end else if (rdRxHold | ~rxEn) begin
            rxAvail <= 1'b0;
         end
         // set wins over the clear command in the same cycle
         if (rxFinish & rxAvail & ~rdRxHold) begin
            ovrErr <= 1'b1;
         end else if (cmdClrErr) begin
            ovrErr <= 1'b0;
         end
         if (rxFinish & ~rxIn) begin
            frameErr <= 1'b1;
         end else if (cmdClrErr) begin
            frameErr <= 1'b0;
         end
         if (rxFinish & rxBadPar) begin
            parErr <= 1'b1;
         end else if (cmdClrErr) begin
            parErr <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// [testbench/debug_uart_regs_asserts.sv]
// assertions on the debug serial unit register interface
// assumes bind onto debug_uart_regs with ce held high
`timescale 1ns/100ps
`default_nettype none
module debug_uart_regs_asserts (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        ce,
   input wire logic [7:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   input wire logic        txd,
   input wire logic        rxDmaEnd,
   input wire logic        txDmaEnd,
   input wire logic        rxDmaBufFull,
   input wire logic        txDmaBufEmpty,
   input wire logic        dccReadPending,
   input wire logic        dccWritePending,
   input wire logic        irq
);
   // ***************************************
   // shadow registers and properties
   // ***************************************
   logic [31:0] maskM;
   logic [31:0] modeM;
   logic        done;
   logic        rdSt;
   logic        rdMask;
   logic        rdMode;
   assign done = (read || write) && !waitrequest && ce;
   assign rdSt = done && read && address == 8'h14;
   assign rdMask = done && read && address == 8'h10;
   assign rdMode = done && read && address == 8'h04;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         maskM <= '0;
         modeM <= '0;
      end else if (done && write) begin
         if (address == 8'h08) maskM <= maskM | (writedata & 32'hc0001afb);
         if (address == 8'h0c) maskM <= maskM & ~writedata;
         if (address == 8'h04) modeM <= writedata & 32'h0000ce00;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   dma_done_a: assert property (rdSt |->
      readdata[4:3] == $past({txDmaEnd, rxDmaEnd}))
      else $error("dma done bits wrong");
   buf_flags_a: assert property (rdSt |->
      readdata[12:11] == $past({rxDmaBufFull, txDmaBufEmpty}))
      else $error("dma buffer bits wrong");
   dcc_flags_a: assert property (rdSt |->
      readdata[31:30] == $past({dccReadPending, dccWritePending}))
      else $error("debug channel bits wrong");
   mask_view_a: assert property (
      rdMask |-> readdata == $past(maskM)) else $error("mask read wrong");
   mode_view_a: assert property (
      rdMode |-> readdata == $past(modeM)) else $error("mode read wrong");
   irq_quiet_a: assert property (
      maskM == '0 |-> !irq) else $error("irq with all masked");
   irq_raise_a: assert property (
      maskM[31] && dccReadPending |-> ##[0:1] irq) else $error("irq missing");
   loop_idle_a: assert property (
      (modeM[15:14] == 2'h2) [*2] |-> txd) else $error("txd low in loop");
   cover property (rdSt && readdata[0]);
   cover property (irq);
   cover property (rdMask && readdata[31]);
endmodule
bind debug_uart_regs debug_uart_regs_asserts chk (.clk(clk), .nrst(nrst),
   .ce(ce), .address(address), .read(read), .write(write),
   .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
   .txd(txd), .rxDmaEnd(rxDmaEnd), .txDmaEnd(txDmaEnd),
   .rxDmaBufFull(rxDmaBufFull), .txDmaBufEmpty(txDmaBufEmpty),
   .dccReadPending(dccReadPending), .dccWritePending(dccWritePending),
   .irq(irq));
`default_nettype wire

// [testbench/serial_terminal_model.sv]
// remote terminal sending frames on the serial receive line
// assumes 16 clocks a bit; frame bits go lsb first, idle line high
`timescale 1ns/100ps
`default_nettype none
module serial_terminal_model (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        go,
   input  wire logic [10:0] frame,
   input  wire logic [3:0]  nbits,
   output logic             rxd,
   output logic             busy
);
   // ***************************************
   // frame shifter
   // ***************************************
   logic [10:0] bits;
   logic [3:0]  left;
   logic [7:0]  tick;
   assign rxd = busy ? bits[0] : 1'b1;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busy <= 1'b0;
         tick <= 8'h00;
      end else if (!busy) begin
         busy <= go;
         bits <= frame;
         left <= nbits;
         tick <= 8'h00;
      end else if (tick == debug_uart_pkg::BIT_CYCLES - 8'h01) begin
         tick <= 8'h00;
         bits <= bits >> 1;
         left <= left - 4'h1;
         busy <= left != 4'h1;
      end else begin
         tick <= tick + 8'h01;
      end
   end
endmodule
`default_nettype wire

// [testbench/debug_uart_regs_tb.sv]
// self-checking bench for the debug serial unit register interface
// assumes the design, its package, checker and terminal model
`timescale 1ns/100ps
`default_nettype none
module debug_uart_regs_tb;
   // ***************************************
   // stimulus, tasks and tests
   // ***************************************
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic        go = 1'b0;
   logic        rxd, txd, irq, waitrequest, busy;
   logic [7:0]  address = 8'h00;
   logic [31:0] writedata = 32'h0, readdata, q;
   logic [5:0]  ext = 6'h00;
   logic [10:0] frame = 11'h7ff;
   logic [3:0]  nbits = 4'h0;
   int          numErrors = 0;
   int          comparisons = 0;
   int          cycles = 0;
   always #5 clk = ~clk;
   debug_uart_regs uut (.clk(clk), .nrst(nrst), .ce(1'b1),
      .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .rxd(rxd), .txd(txd),
      .rxDmaEnd(ext[0]), .txDmaEnd(ext[1]), .rxDmaBufFull(ext[2]),
      .txDmaBufEmpty(ext[3]), .dccReadPending(ext[4]),
      .dccWritePending(ext[5]), .irq(irq));
   serial_terminal_model term (.clk(clk), .nrst(nrst), .go(go),
      .frame(frame), .nbits(nbits), .rxd(rxd), .busy(busy));
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, numErrors);
      if (numErrors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         numErrors++;
         results();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         numErrors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      read <= !w;
      write <= w;
      address <= a;
      writedata <= d;
      do @(posedge clk); while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      acc(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   task automatic waitBit(input int b);
      for (int k = 0; k < 200; k++) begin
         acc(1'b0, 8'h14, 32'h0);
         if (q[b] === 1'b1) break;
      end
   endtask
   task automatic send(input logic [10:0] f, input logic [3:0] n);
      frame <= f;
      nbits <= n;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      for (int k = 0; k < 300 && busy !== 1'b0; k++) @(posedge clk);
      waitBit(0);
   endtask
   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      rc(8'h04, 32'h0);
      rc(8'h10, 32'h0);
      rc(8'h14, 32'h0);
      rc(8'h20, 32'h0);
      $display("test reset values done");
      ext <= 6'h3f;
      rc(8'h14, 32'hc0001818);
      acc(1'b1, 8'h08, 32'hffffffff);
      rc(8'h10, 32'hc0001afb);
      acc(1'b1, 8'h0c, 32'h7fffffff);
      acc(1'b1, 8'h08, 32'h0);
      rc(8'h10, 32'h80000000);
      @(negedge clk);
      chk({31'h0, irq}, 32'h1);
      ext <= 6'h00;
      rc(8'h10, 32'h80000000);
      @(negedge clk);
      chk({31'h0, irq}, 32'h0);
      acc(1'b1, 8'h0c, 32'hffffffff);
      $display("test mirrors and mask done");
      for (int i = 0; i < 8; i++) begin
         acc(1'b1, 8'h04, 32'(i) << 9 | 32'(i % 4) << 14);
         rc(8'h04, 32'(i) << 9 | 32'(i % 4) << 14);
      end
      acc(1'b1, 8'h04, 32'hffffffff);
      rc(8'h04, 32'h0000ce00);
      $display("test mode field done");
      acc(1'b1, 8'h04, 32'h00000800);
      acc(1'b1, 8'h00, 32'h00000010);
      send({2'b11, 8'ha5, 1'b0}, 4'ha);
      rc(8'h14, 32'h1);
      rc(8'h18, 32'ha5);
      rc(8'h14, 32'h0);
      send({2'b10, 8'h3c, 1'b0}, 4'ha);
      send({2'b11, 8'h55, 1'b0}, 4'ha);
      acc(1'b0, 8'h14, 32'h0);
      chk(q & 32'h61, 32'h61);
      acc(1'b1, 8'h00, 32'h00000100);
      acc(1'b0, 8'h14, 32'h0);
      chk(q & 32'he0, 32'h0);
      acc(1'b0, 8'h18, 32'h0);
      acc(1'b1, 8'h04, 32'h0);
      send({2'b10, 8'h01, 1'b0}, 4'hb);
      acc(1'b0, 8'h14, 32'h0);
      chk(q & 32'h80, 32'h80);
      acc(1'b0, 8'h18, 32'h0);
      $display("test receive and errors done");
      acc(1'b1, 8'h04, 32'h00008800);
      acc(1'b1, 8'h00, 32'h00000140);
      rc(8'h14, 32'h202);
      acc(1'b1, 8'h1c, 32'h3c);
      acc(1'b1, 8'h1c, 32'h5a);
      rc(8'h14, 32'h0);
      waitBit(0);
      rc(8'h18, 32'h3c);
      waitBit(0);
      rc(8'h18, 32'h5a);
      waitBit(9);
      rc(8'h14, 32'h202);
      $display("test loopback transmit done");
      results();
   end
endmodule
`default_nettype wire
